// ### rtl/rst_irq_defines.vh
// Purpose: Shared constants for the reset and interrupt pin logic
// Assumes: 50 MHz bus clock
// Notes: Counts are in bus clock cycles
`ifndef RST_IRQ_DEFINES_VH
`define RST_IRQ_DEFINES_VH

`define RST_DRIVE_CYCLES 6'd16
`define RST_SAMPLE_DELAY 6'd8
`define RST_SAMPLE_AT 6'd24
`define RST_EXT_MIN_CYCLES 6'd32
`define MODE_WIDTH 3
`define MODE_SMOD_BIT 2
`define MODE_B_BIT 1
`define MODE_A_BIT 0
`define VEC_NONE 2'b00
`define VEC_RESET 2'b01
`define VEC_WATCHDOG 2'b10
`define VEC_CLOCK_MON 2'b11

`endif

// ### rtl/pin_sync.v
// Purpose: Three-stage synchroniser for a pin input
// Assumes: Single bus clock
// Notes: Output changes once stages two and three agree
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
  parameter RESET_VALUE = 1'b1
) (
  input wire clk_i,
  input wire rst_i,
  input wire pin_i,
  output reg level_o
);

  reg stage1;
  reg stage2;
  reg stage3;

  always @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= RESET_VALUE;
      stage2 <= RESET_VALUE;
      stage3 <= RESET_VALUE;
      level_o <= RESET_VALUE;
    end else begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level_o <= stage3;
      end
    end
  end

endmodule

`default_nettype wire

// ### rtl/irq_detect.v
// Purpose: Interrupt request detector for one active-low pin
// Assumes: Pin already synchronised
// Notes: Edge mode latches a falling edge until acknowledged
`timescale 1ns/100ps
`default_nettype none

module irq_detect (
  input wire clk_i,
  input wire rst_i,
  input wire level_n_i,
  input wire edge_mode_i,
  input wire mask_i,
  input wire ack_i,
  output reg request_o
);

  reg prev_n;
  reg edge_latched;
  wire fall;
  wire pending;

  assign fall = prev_n & ~level_n_i;
  assign pending = edge_mode_i ? edge_latched : ~level_n_i;

  always @(posedge clk_i) begin
    if (rst_i) begin
      prev_n <= 1'b1;
      edge_latched <= 1'b0;
      request_o <= 1'b0;
    end else begin
      prev_n <= level_n_i;
      // Set wins over acknowledge
      if (fall) begin
        edge_latched <= 1'b1;
      end else if (ack_i) begin
        edge_latched <= 1'b0;
      end
      request_o <= pending & ~mask_i;
    end
  end

endmodule

`default_nettype wire

// ### rtl/reset_irq_pins.v
// Purpose: Reset pin, interrupt pins and mode pin logic
// Assumes: One 50 MHz bus clock; pins are asynchronous
// Notes: Mask bits stand for the condition code register bits
`timescale 1ns/100ps
`default_nettype none
`include "rst_irq_defines.vh"

module reset_irq_pins (
  input wire clk_i,
  input wire rst_i,
  input wire reset_pin_n_i,
  input wire watchdog_fail_i,
  input wire clock_mon_fail_i,
  input wire irq_pin_n_i,
  input wire nonmaskable_irq_in_n_i,
  input wire special_mode_select_pin_i,
  input wire mode_select_a_pin_i,
  input wire mode_select_b_pin_i,
  input wire edge_select_wr_i,
  input wire edge_select_i,
  input wire pullup_enable_wr_i,
  input wire pullup_enable_i,
  input wire irq_mask_clear_i,
  input wire irq_mask_set_i,
  input wire nonmaskable_mask_clear_i,
  input wire irq_ack_i,
  input wire nonmaskable_ack_i,
  input wire queue_track_en_i,
  input wire queue_track_0_i,
  input wire queue_track_1_i,
  output reg reset_pin_o,
  output reg reset_pin_oe_o,
  output reg in_reset_o,
  output reg [1:0] vector_sel_o,
  output reg vector_valid_o,
  output reg [`MODE_WIDTH-1:0] mode_o,
  output reg edge_select_o,
  output reg pullup_enable_o,
  output reg irq_pullup_o,
  output reg nonmaskable_pullup_o,
  output reg mode_pulldown_o,
  output reg irq_mask_o,
  output reg nonmaskable_mask_o,
  output reg irq_level_o,
  output reg nonmaskable_level_o,
  output reg irq_request_o,
  output reg nonmaskable_request_o,
  output reg mode_a_pin_o,
  output reg mode_b_pin_o,
  output reg mode_pins_oe_o
);

  // ----------------------------------------------------------------
  // Local states
  // ----------------------------------------------------------------
  localparam ST_RUN = 4'b0001;
  localparam ST_DRIVE = 4'b0010;
  localparam ST_WAIT = 4'b0100;
  localparam ST_HOLD = 4'b1000;

  reg [3:0] state;
  reg [5:0] count;
  reg fail_clock;
  reg ext_seen;
  wire reset_sync_n;
  wire irq_sync_n;
  wire nmi_sync_n;
  wire irq_req;
  wire nmi_req;
  wire failure;
  wire core_reset;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  pin_sync #(.RESET_VALUE(1'b1)) u_sync_reset (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(reset_pin_n_i),
    .level_o(reset_sync_n)
  );

  pin_sync #(.RESET_VALUE(1'b1)) u_sync_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(irq_pin_n_i),
    .level_o(irq_sync_n)
  );

  pin_sync #(.RESET_VALUE(1'b1)) u_sync_nmi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i(nonmaskable_irq_in_n_i),
    .level_o(nmi_sync_n)
  );

  assign failure = watchdog_fail_i | clock_mon_fail_i;

  // ----------------------------------------------------------------
  // Reset pin sequencer
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_HOLD;
      count <= 6'd0;
      fail_clock <= 1'b0;
      ext_seen <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          count <= 6'd0;
          if (failure) begin
            state <= ST_DRIVE;
            fail_clock <= clock_mon_fail_i & ~watchdog_fail_i;
          end else if (!reset_sync_n) begin
            state <= ST_HOLD;
            ext_seen <= 1'b1;
          end
        end
        ST_DRIVE: begin
          count <= count + 6'd1;
          if (count == `RST_DRIVE_CYCLES - 6'd1) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          count <= count + 6'd1;
          if (count == `RST_SAMPLE_AT - 6'd1) begin
            ext_seen <= ~reset_sync_n;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          count <= 6'd0;
          if (reset_sync_n) begin
            state <= ST_RUN;
          end
        end
        default: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  assign core_reset = rst_i | ~reset_pin_n_i | (state != ST_RUN);

  // ----------------------------------------------------------------
  // Pin drive, vector and status outputs
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= 1'b0;
      in_reset_o <= 1'b1;
      vector_sel_o <= `VEC_RESET;
      vector_valid_o <= 1'b0;
    end else begin
      reset_pin_o <= 1'b0;
      reset_pin_oe_o <= (state == ST_RUN && failure) ||
        (state == ST_DRIVE && count != `RST_DRIVE_CYCLES - 6'd1);
      in_reset_o <= core_reset;
      vector_valid_o <= 1'b0;
      if (state == ST_WAIT && count == `RST_SAMPLE_AT - 6'd1) begin
        if (!reset_sync_n) begin
          vector_sel_o <= `VEC_RESET;
        end else if (fail_clock) begin
          vector_sel_o <= `VEC_CLOCK_MON;
        end else begin
          vector_sel_o <= `VEC_WATCHDOG;
        end
      end else if (state == ST_HOLD && ext_seen) begin
        vector_sel_o <= `VEC_RESET;
      end
      if (state == ST_HOLD && reset_sync_n) begin
        vector_valid_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode pins
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      mode_o <= 3'b000;
      mode_pulldown_o <= 1'b1;
      mode_a_pin_o <= 1'b0;
      mode_b_pin_o <= 1'b0;
      mode_pins_oe_o <= 1'b0;
    end else begin
      if (state == ST_HOLD) begin
        mode_o[`MODE_SMOD_BIT] <= special_mode_select_pin_i;
        mode_o[`MODE_B_BIT] <= mode_select_b_pin_i;
        mode_o[`MODE_A_BIT] <= mode_select_a_pin_i;
      end
      mode_pulldown_o <= core_reset;
      mode_pins_oe_o <= ~core_reset & queue_track_en_i;
      mode_a_pin_o <= queue_track_0_i;
      mode_b_pin_o <= queue_track_1_i;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt configuration and masks
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (core_reset) begin
      edge_select_o <= 1'b0;
      irq_mask_o <= 1'b1;
      nonmaskable_mask_o <= 1'b1;
      pullup_enable_o <= 1'b1;
    end else begin
      if (edge_select_wr_i) begin
        edge_select_o <= edge_select_i;
      end
      if (pullup_enable_wr_i) begin
        pullup_enable_o <= pullup_enable_i;
      end
      if (irq_mask_set_i) begin
        irq_mask_o <= 1'b1;
      end else if (irq_mask_clear_i) begin
        irq_mask_o <= 1'b0;
      end
      if (nonmaskable_mask_clear_i) begin
        nonmaskable_mask_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt detection
  // ----------------------------------------------------------------
  // in level mode a held low line requests once unmasked
  irq_detect u_irq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_n_i(irq_sync_n),
    .edge_mode_i(edge_select_o),
    .mask_i(irq_mask_o),
    .ack_i(irq_ack_i),
    .request_o(irq_req)
  );

  irq_detect u_nmi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .level_n_i(nmi_sync_n),
    .edge_mode_i(1'b0),
    .mask_i(nonmaskable_mask_o),
    .ack_i(nonmaskable_ack_i),
    .request_o(nmi_req)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_request_o <= 1'b0;
      nonmaskable_request_o <= 1'b0;
      irq_level_o <= 1'b1;
      nonmaskable_level_o <= 1'b1;
      irq_pullup_o <= 1'b1;
      nonmaskable_pullup_o <= 1'b1;
    end else begin
      irq_request_o <= irq_req & ~irq_mask_o;
      nonmaskable_request_o <= nmi_req & ~nonmaskable_mask_o;
      irq_level_o <= irq_sync_n;
      nonmaskable_level_o <= nmi_sync_n;
      irq_pullup_o <= pullup_enable_o | core_reset;
      nonmaskable_pullup_o <= pullup_enable_o | core_reset;
    end
  end

endmodule

`default_nettype wire

// ### tb/reset_irq_pins_props.sv
// Purpose: Concurrent checks on the reset and interrupt pin block
// Assumes: One bus clock, synchronous active-high reset
// Notes: Bound to the block below the module
`timescale 1ns/100ps
`default_nettype none
`include "rst_irq_defines.vh"
module reset_irq_pins_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic reset_pin_n_i,
  input wire logic watchdog_fail_i,
  input wire logic clock_mon_fail_i,
  input wire logic reset_pin_oe_o,
  input wire logic in_reset_o,
  input wire logic [1:0] vector_sel_o,
  input wire logic vector_valid_o,
  input wire logic [`MODE_WIDTH-1:0] mode_o,
  input wire logic edge_select_o,
  input wire logic irq_pullup_o,
  input wire logic mode_pulldown_o,
  input wire logic irq_mask_o,
  input wire logic nonmaskable_mask_o,
  input wire logic irq_level_o,
  input wire logic irq_request_o
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence pin_back;
    $fell(reset_pin_oe_o) ##0 reset_pin_n_i [*8];
  endsequence
  sequence pin_held;
    $fell(reset_pin_oe_o) ##0 !reset_pin_n_i [*8];
  endsequence
  a_drive_sixteen: assert property (
    $rose(reset_pin_oe_o) |-> reset_pin_oe_o [*8] ##1 reset_pin_oe_o [*8] ##1 !reset_pin_oe_o
  ) else $error("reset drive length wrong");
  a_drive_on_fail: assert property (
    !in_reset_o && !reset_pin_oe_o && (watchdog_fail_i || clock_mon_fail_i) |=> reset_pin_oe_o
  ) else $error("failure did not drive reset");
  a_vector_internal: assert property (
    pin_back |-> ##[0:8] vector_sel_o[1]
  ) else $error("internal vector not chosen");
  a_vector_external: assert property (
    pin_held |-> ##[0:8] vector_sel_o == `VEC_RESET
  ) else $error("reset vector not chosen");
  a_valid_pulse: assert property (
    vector_valid_o |=> !vector_valid_o ##[0:1] !in_reset_o
  ) else $error("leaving reset out of step");
  a_reset_state: assert property (
    in_reset_o && $past(in_reset_o) |-> irq_mask_o && nonmaskable_mask_o && !edge_select_o
      && irq_pullup_o && mode_pulldown_o
  ) else $error("reset defaults not held");
  a_mode_hold: assert property (
    !in_reset_o && !$past(in_reset_o) |-> $stable(mode_o)
  ) else $error("mode changed after reset");
  a_level_request: assert property (
    (!edge_select_o && !irq_mask_o && !irq_level_o) [*3] |-> irq_request_o
  ) else $error("low level not requested");
  a_masked_quiet: assert property (
    irq_mask_o && $past(irq_mask_o) |-> !irq_request_o
  ) else $error("masked request seen");
endmodule
bind reset_irq_pins reset_irq_pins_props u_props (.*);
`default_nettype wire

// ### tb/reset_irq_far_side.sv
// Purpose: External reset circuit and open-drain interrupt sources
// Assumes: Commands from the bench on the bus clock
// Notes: A released line without pull-up toggles every cycle
`timescale 1ns/100ps
`default_nettype none
module reset_irq_far_side (
  input wire logic clk_i,
  input wire logic dev_drive_i,
  input wire logic ext_go_i,
  input wire logic [1:0] go_i,
  input wire logic [1:0] ack_i,
  input wire logic [1:0] pull_i,
  output logic rst_line_o,
  output logic [1:0] line_o
);
  logic [5:0] ext_cnt = 6'h00;
  logic [1:0] low = 2'h0;
  logic drift = 1'b0;
  always @(posedge clk_i) begin
    drift <= ~drift;
    if (ext_go_i) begin
      ext_cnt <= 6'h20;
    end else if (ext_cnt != 6'h00) begin
      ext_cnt <= ext_cnt - 6'h01;
    end
    low <= go_i | (low & ~ack_i);
  end
  assign rst_line_o = ~(dev_drive_i | (ext_cnt != 6'h00));
  assign line_o = ~low & (pull_i | {2{drift}});
endmodule
`default_nettype wire

// ### tb/reset_irq_pins_bench.sv
// Purpose: Self-checking bench for the reset and interrupt pins
// Assumes: 50 MHz clock, inputs change 2 ns after each edge
// Notes: Far side is reset_irq_far_side
`timescale 1ns/100ps
`default_nettype none
`include "rst_irq_defines.vh"
module reset_irq_pins_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic watchdog_fail_i, clock_mon_fail_i, special_mode_select_pin_i, mode_select_a_pin_i;
  logic mode_select_b_pin_i, edge_select_wr_i, edge_select_i, pullup_enable_wr_i;
  logic pullup_enable_i, irq_mask_clear_i, irq_mask_set_i, nonmaskable_mask_clear_i;
  logic irq_ack_i, nonmaskable_ack_i, queue_track_en_i, queue_track_0_i, queue_track_1_i;
  logic ext_go, irq_go, nm_go;
  wire logic reset_pin_n_i, irq_pin_n_i, nonmaskable_irq_in_n_i, reset_pin_o, reset_pin_oe_o;
  wire logic in_reset_o, vector_valid_o, edge_select_o, pullup_enable_o, irq_pullup_o;
  wire logic nonmaskable_pullup_o, mode_pulldown_o, irq_mask_o, nonmaskable_mask_o;
  wire logic irq_level_o, nonmaskable_level_o, irq_request_o, nonmaskable_request_o;
  wire logic mode_a_pin_o, mode_b_pin_o, mode_pins_oe_o;
  wire logic [1:0] vector_sel_o;
  wire logic [`MODE_WIDTH-1:0] mode_o;
  int error_cnt = 0;
  int n_compared = 0;
  int cycles = 0;
  reset_irq_pins uut (.*);
  reset_irq_far_side far_side (.clk_i, .dev_drive_i(reset_pin_oe_o), .ext_go_i(ext_go),
    .go_i({nm_go, irq_go}), .ack_i({nonmaskable_ack_i, irq_ack_i}),
    .pull_i({nonmaskable_pullup_o, irq_pullup_o}), .rst_line_o(reset_pin_n_i),
    .line_o({nonmaskable_irq_in_n_i, irq_pin_n_i}));
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      conclude;
    end
  end
  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #2;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_defaults;
    check(8'({in_reset_o, irq_mask_o, nonmaskable_mask_o, edge_select_o}), 8'h0e);
    check(8'({irq_pullup_o, nonmaskable_pullup_o, mode_pulldown_o}), 8'h07);
    for (int i = 0; i < 50 && in_reset_o !== 1'b0; i++) tick(1);
    {special_mode_select_pin_i, mode_select_b_pin_i, mode_select_a_pin_i} = 3'b010;
    tick(3);
    check(8'(mode_o), 8'h05);
    check(8'({mode_pulldown_o, in_reset_o, irq_mask_o}), 8'h01);
  endtask
  task automatic t_level;
    pulse(irq_mask_clear_i);
    pulse(irq_go);
    tick(6);
    check(8'({irq_request_o, irq_level_o}), 8'h02);
    pulse(irq_mask_set_i);
    tick(3);
    check(8'(irq_request_o), 8'h00);
    pulse(irq_mask_clear_i);
    tick(3);
    check(8'(irq_request_o), 8'h01);
    pulse(irq_ack_i);
    tick(6);
    check(8'({irq_request_o, irq_level_o}), 8'h01);
    pulse(nonmaskable_mask_clear_i);
    pulse(nm_go);
    tick(6);
    check(8'({nonmaskable_request_o, nonmaskable_level_o}), 8'h02);
    pulse(nonmaskable_ack_i);
    tick(6);
    check(8'(nonmaskable_request_o), 8'h00);
  endtask
  task automatic t_edge_pullup;
    edge_select_i = 1'b1;
    pulse(edge_select_wr_i);
    pulse(irq_go);
    tick(7);
    check(8'({edge_select_o, irq_request_o}), 8'h03);
    pulse(irq_ack_i);
    tick(6);
    check(8'(irq_request_o), 8'h00);
    pulse(pullup_enable_wr_i);
    {queue_track_en_i, queue_track_1_i, queue_track_0_i} = 3'b101;
    tick(2);
    check(8'({pullup_enable_o, irq_pullup_o, nonmaskable_pullup_o}), 8'h00);
    check(8'({mode_pins_oe_o, mode_b_pin_o, mode_a_pin_o}), 8'h05);
    queue_track_en_i = 1'b0;
  endtask
  task automatic t_internal;
    int n;
    for (int k = 0; k < 2; k++) begin
      watchdog_fail_i = (k == 0);
      clock_mon_fail_i = (k == 1);
      tick(1);
      watchdog_fail_i = 1'b0;
      clock_mon_fail_i = 1'b0;
      n = 0;
      while (reset_pin_oe_o === 1'b1 && n < 40) begin
        n++;
        tick(1);
      end
      check(8'(n), 8'h10);
      check(8'({in_reset_o, reset_pin_o}), 8'h02);
      for (int i = 0; i < 60 && vector_valid_o !== 1'b1; i++) tick(1);
      check(8'(vector_sel_o), 8'(k == 0 ? `VEC_WATCHDOG : `VEC_CLOCK_MON));
      tick(2);
      check(8'({in_reset_o, irq_pullup_o, edge_select_o, irq_mask_o}), 8'h05);
    end
  endtask
  task automatic t_external(input logic fail);
    {special_mode_select_pin_i, mode_select_b_pin_i, mode_select_a_pin_i} = {fail, 2'b10};
    watchdog_fail_i = fail;
    ext_go = 1'b1;
    tick(1);
    watchdog_fail_i = 1'b0;
    ext_go = 1'b0;
    tick(8);
    check(8'({in_reset_o, reset_pin_oe_o}), 8'({1'b1, fail}));
    for (int i = 0; i < 100 && vector_valid_o !== 1'b1; i++) tick(1);
    check(8'(vector_sel_o), 8'(`VEC_RESET));
    tick(2);
    check(8'(mode_o), 8'({fail, 2'b10}));
  endtask
  initial begin
    {watchdog_fail_i, clock_mon_fail_i, edge_select_wr_i, edge_select_i, pullup_enable_wr_i,
      pullup_enable_i, irq_mask_clear_i, irq_mask_set_i, nonmaskable_mask_clear_i, irq_ack_i,
      nonmaskable_ack_i, queue_track_en_i, queue_track_0_i, queue_track_1_i, ext_go, irq_go,
      nm_go} = '0;
    {special_mode_select_pin_i, mode_select_b_pin_i, mode_select_a_pin_i} = 3'b101;
    tick(2);
    rst_i = 1'b0;
    t_defaults;
    t_level;
    t_edge_pullup;
    t_internal;
    t_external(1'b0);
    t_external(1'b1);
    conclude;
  end
endmodule
`default_nettype wire
